/* File: reset_power_pkg.sv */
// Constants and types for the reset and power-down controller
package reset_power_pkg;

	// Clock and timing
	localparam int CLK_MHZ          = 50;
	localparam int CLK_PERIOD_NS    = 1000 / CLK_MHZ;
	localparam int PIN_DRIVE_CYCLES = 8;
	localparam int OSC_START_US     = 1000;
	localparam int PLL_LOCK_US      = 200;
	localparam int OSC_START_CYCLES = OSC_START_US * CLK_MHZ;
	localparam int PLL_LOCK_CYCLES  = PLL_LOCK_US * CLK_MHZ;

	// Register word indices, byte address is four times the index
	localparam logic [5:0] IDX_SYS_CTRL   = 6'h00;
	localparam logic [5:0] IDX_CAUSE      = 6'h01;
	localparam logic [5:0] IDX_CLK_CTRL0  = 6'h02;
	localparam logic [5:0] IDX_WD_KEY     = 6'h03;
	localparam logic [5:0] IDX_WD_CTRL    = 6'h04;
	localparam logic [5:0] IDX_WD_COUNT   = 6'h05;
	localparam logic [5:0] IDX_CPU_STATUS = 6'h06;
	localparam logic [5:0] IDX_CPU_IRQ    = 6'h07;
	localparam logic [5:0] IDX_CPU_MISC   = 6'h08;
	localparam logic [5:0] IDX_CPU_PC     = 6'h09;
	localparam logic [5:0] IDX_PWR_STATE  = 6'h0A;

	// Field positions and values
	localparam int SCR_CLR_POS     = 14;
	localparam int SCR_SET_POS     = 15;
	localparam int CAUSE_POR       = 0;
	localparam int CAUSE_PIN       = 1;
	localparam int CAUSE_WDOG      = 2;
	localparam int CAUSE_SW        = 3;
	localparam int CAUSE_ILLEGAL   = 4;
	localparam logic [7:0] WD_KEY_ARM   = 8'h55;
	localparam logic [7:0] WD_KEY_CLEAR = 8'hAA;
	localparam int WDC_CHK_POS     = 3;
	localparam logic [2:0] WDC_CHK_VAL  = 3'h5;
	localparam int WDC_DIS_POS     = 6;
	localparam logic [1:0] LPM_LIGHT    = 2'h0;
	localparam logic [1:0] LPM_DEEP     = 2'h1;
	localparam logic [1:0] LPM_PLL_DOWN = 2'h2;
	localparam logic [1:0] LPM_OSC_DOWN = 2'h3;

	// Power states
	typedef enum logic [2:0] {
		PWR_RUN, PWR_LIGHT, PWR_DEEP, PWR_PLL_DOWN,
		PWR_OSC_DOWN, PWR_OSC_WAIT, PWR_PLL_WAIT
	} pwr_state_type;

	typedef struct packed {
		logic cpu;
		logic sys;
		logic wdog;
		logic pll;
		logic osc;
		logic full_speed;
	} clk_gate_type;

	typedef struct packed {
		logic       carry;
		logic       irq_disable;
		logic       ram_map;
		logic [1:0] prod_shift;
		logic       sign_ext;
		logic       ext_flag;
		logic       wrap;
	} cpu_status_type;

	typedef struct packed {
		logic [15:0]    pc;
		cpu_status_type st;
		logic [2:0]     wait_states;
		logic [5:0]     int_flag;
		logic [5:0]     int_mask;
		logic [15:0]    repeat_cnt;
		logic [7:0]     mem_alloc;
	} cpu_init_type;

	typedef struct packed {
		logic        hsel;
		logic [31:0] haddr;
		logic [1:0]  htrans;
		logic        hwrite;
		logic [2:0]  hsize;
		logic [31:0] hwdata;
		logic        hready;
	} ahb_req_type;

	typedef struct packed {
		logic [31:0] hrdata;
		logic        hreadyout;
		logic        hresp;
	} ahb_resp_type;

	typedef struct packed {
		logic          ahb_act;
		logic          ahb_wr;
		logic [5:0]    ahb_idx;
		ahb_resp_type  resp;
		logic [3:0]    drive_cnt;
		logic          pin_oe;
		logic          cpu_reset;
		logic [4:0]    cause;
		logic          scr_clr;
		logic          scr_set;
		logic [1:0]    lpm;
		logic [7:0]    wd_cnt;
		logic          wd_armed;
		logic          wd_dis;
		cpu_init_type  cpu;
		pwr_state_type pwr;
		logic [15:0]   wait_cnt;
		clk_gate_type  clk;
		logic          irq_grant;
	} core_state_type;

	// Reset values
	localparam cpu_status_type ST_RESET = 8'hC6;
	localparam logic [2:0] WAIT_MAX     = 3'h7;
	localparam cpu_init_type CPU_RESET  = '{pc: 16'h0000, st: ST_RESET,
		wait_states: WAIT_MAX, int_flag: 6'h00, int_mask: 6'h00,
		repeat_cnt: 16'h0000, mem_alloc: 8'h00};
	localparam clk_gate_type CLK_RESET  = 6'h3F;
	localparam logic [4:0] CAUSE_RESET  = 5'h01;
	localparam core_state_type STATE_RESET = '{ahb_act: 1'b0, ahb_wr: 1'b0,
		ahb_idx: 6'h00, resp: '{hrdata: 32'h00000000, hreadyout: 1'b1, hresp: 1'b0},
		drive_cnt: 4'h8, pin_oe: 1'b1, cpu_reset: 1'b1, cause: CAUSE_RESET,
		scr_clr: 1'b1, scr_set: 1'b0, lpm: LPM_LIGHT, wd_cnt: 8'h00,
		wd_armed: 1'b0, wd_dis: 1'b0, cpu: CPU_RESET, pwr: PWR_RUN,
		wait_cnt: 16'h0000, clk: CLK_RESET, irq_grant: 1'b0};

endpackage

/* File: reset_and_powerdown_control.sv */
// Reset collection, reset pin drive, reset init and power-down sequencing
`timescale 1ns/1ps

//Contract
//- Reset outranks every interrupt request
//- Watchdog overflow or bad key/control resets
//- Clear bit 14 or set 15 resets
//- Power-on input or low voltage resets
//- Unmapped frame access causes illegal reset
//- Drive reset pin low eight cycles minimum
//- Stay reset while supply bad or pin low
//- Five sticky reset cause bits, readable
//- Reset stops CPU, keeps RAM, fetch 0
//- Status bits take fixed reset values
//- Clear flags and mask, disable maskable
//- Clear repeat, mem alloc; max wait states
//- Other CPU registers untouched by reset
//- Power-down only on sleep, mode field
//- Decode 00 light, 01 deep, 10 PLL
//- 11 oscillator down, exits pin irq/reset
//- Light sleep stops CPU, exits any irq
//- Deep sleep stops CPU and system clocks
//- PLL down waits relock before full speed
//- Oscillator down waits oscillator then PLL
//- Three clock domains gated independently
//- Power-down keeps state; reset changes init only
module reset_and_powerdown_control #(
	parameter int unsigned OSC_START_CYCLES = reset_power_pkg::OSC_START_CYCLES,
	parameter int unsigned PLL_LOCK_CYCLES  = reset_power_pkg::PLL_LOCK_CYCLES
) (
	// Clock and reset
	input  wire logic                         ref_clk_i,
	input  wire logic                         rst_i,
	// Register bus
	input  wire reset_power_pkg::ahb_req_type ahb_i,
	output reset_power_pkg::ahb_resp_type     ahb_o,
	// Reset sources
	input  wire logic                         reset_pin_n_i,
	input  wire logic                         power_on_reset_input_i,
	input  wire logic                         low_voltage_i,
	input  wire logic                         illegal_access_i,
	input  wire logic                         watchdog_tick_i,
	// Reset pin drive, open drain
	output logic                              reset_pin_o,
	output logic                              reset_pin_oe_o,
	// CPU side
	input  wire logic                         sleep_i,
	input  wire logic                         irq_req_i,
	input  wire logic                         wake_irq_i,
	input  wire logic                         pin_irq_i,
	output logic                              cpu_reset_o,
	output logic                              irq_grant_o,
	output reset_power_pkg::cpu_init_type     cpu_init_o,
	// Clock domain gates
	output reset_power_pkg::clk_gate_type     clk_gate_o,
	output reset_power_pkg::pwr_state_type    pwr_state_o
);

	reset_power_pkg::core_state_type state_ff;
	reset_power_pkg::core_state_type nxt_state;

	logic        addr_ok;
	logic        mapped;
	logic [5:0]  idx;
	logic [31:0] wdat;
	logic        sw_evt;
	logic        wd_evt;
	logic        illegal_evt;
	logic        pin_ext;
	logic        supply_bad;
	logic [4:0]  src;

	localparam logic [15:0] OSC_LOAD = 16'(OSC_START_CYCLES - 1);
	localparam logic [15:0] PLL_LOAD = 16'(PLL_LOCK_CYCLES - 1);

	// Word decode of the register frame
	function automatic logic reg_mapped(input logic [5:0] i);
		reg_mapped = (i <= reset_power_pkg::IDX_PWR_STATE);
	endfunction

	// Clock enables per power state
	function automatic reset_power_pkg::clk_gate_type clk_map(
		input reset_power_pkg::pwr_state_type p);
		reset_power_pkg::clk_gate_type g;
		case (p)
			reset_power_pkg::PWR_RUN:      g = 6'h3F;
			reset_power_pkg::PWR_LIGHT:    g = 6'h1E;
			reset_power_pkg::PWR_DEEP:     g = 6'h0E;
			reset_power_pkg::PWR_PLL_DOWN: g = 6'h0A;
			reset_power_pkg::PWR_OSC_DOWN: g = 6'h00;
			reset_power_pkg::PWR_OSC_WAIT: g = 6'h02;
			reset_power_pkg::PWR_PLL_WAIT: g = 6'h0E;
			default:                       g = 6'h3F;
		endcase
		clk_map = g;
	endfunction

	// Read mux over the post-write image
	function automatic logic [31:0] rd_word(input logic [5:0] i,
		input reset_power_pkg::core_state_type s);
		logic [31:0] w;
		w = 32'h00000000;
		case (i)
			reset_power_pkg::IDX_SYS_CTRL: begin
				w[reset_power_pkg::SCR_CLR_POS] = s.scr_clr;
				w[reset_power_pkg::SCR_SET_POS] = s.scr_set;
			end
			reset_power_pkg::IDX_CAUSE:      w[4:0] = s.cause;
			reset_power_pkg::IDX_CLK_CTRL0:  w[1:0] = s.lpm;
			reset_power_pkg::IDX_WD_CTRL: begin
				w[reset_power_pkg::WDC_CHK_POS +: 3] = reset_power_pkg::WDC_CHK_VAL;
				w[reset_power_pkg::WDC_DIS_POS] = s.wd_dis;
			end
			reset_power_pkg::IDX_WD_COUNT:   w[7:0] = s.wd_cnt;
			reset_power_pkg::IDX_CPU_STATUS: w[10:0] = {s.cpu.wait_states, s.cpu.st};
			reset_power_pkg::IDX_CPU_IRQ:    w[13:0] = {s.cpu.int_mask, 2'h0, s.cpu.int_flag};
			reset_power_pkg::IDX_CPU_MISC:   w[23:0] = {s.cpu.mem_alloc, s.cpu.repeat_cnt};
			reset_power_pkg::IDX_CPU_PC:     w[15:0] = s.cpu.pc;
			reset_power_pkg::IDX_PWR_STATE:  w[2:0] = s.pwr;
			default:                         w = 32'h00000000;
		endcase
		rd_word = w;
	endfunction

	// Next-state logic for the whole block
	always_comb begin
		nxt_state = state_ff;
		sw_evt = 1'b0;
		wd_evt = 1'b0;
		wdat = ahb_i.hwdata;
		addr_ok = ahb_i.hsel & ahb_i.hready & ahb_i.htrans[1];
		idx = ahb_i.haddr[7:2];
		mapped = reg_mapped(idx) & (ahb_i.haddr[11:8] == 4'h0);

		// Data phase of a write
		if (state_ff.ahb_act & state_ff.ahb_wr) begin
			case (state_ff.ahb_idx)
				reset_power_pkg::IDX_SYS_CTRL: begin
					nxt_state.scr_clr = wdat[reset_power_pkg::SCR_CLR_POS];
					nxt_state.scr_set = wdat[reset_power_pkg::SCR_SET_POS];
					sw_evt = ~wdat[reset_power_pkg::SCR_CLR_POS]
						| wdat[reset_power_pkg::SCR_SET_POS];
				end
				reset_power_pkg::IDX_CAUSE: begin
					nxt_state.cause = state_ff.cause & ~wdat[4:0];
				end
				reset_power_pkg::IDX_CLK_CTRL0: begin
					nxt_state.lpm = wdat[1:0];
				end
				reset_power_pkg::IDX_WD_KEY: begin
					// Any value outside the two-step key is taken as tampering
					if (wdat[7:0] == reset_power_pkg::WD_KEY_ARM) begin
						nxt_state.wd_armed = 1'b1;
					end else if ((wdat[7:0] == reset_power_pkg::WD_KEY_CLEAR) & state_ff.wd_armed) begin
						nxt_state.wd_armed = 1'b0;
						nxt_state.wd_cnt = 8'h00;
					end else begin
						wd_evt = 1'b1;
					end
				end
				reset_power_pkg::IDX_WD_CTRL: begin
					if (wdat[reset_power_pkg::WDC_CHK_POS +: 3] != reset_power_pkg::WDC_CHK_VAL) begin
						wd_evt = 1'b1;
					end else begin
						nxt_state.wd_dis = wdat[reset_power_pkg::WDC_DIS_POS];
					end
				end
				reset_power_pkg::IDX_CPU_STATUS: begin
					nxt_state.cpu.st = wdat[7:0];
					nxt_state.cpu.wait_states = wdat[10:8];
				end
				reset_power_pkg::IDX_CPU_IRQ: begin
					nxt_state.cpu.int_flag = wdat[5:0];
					nxt_state.cpu.int_mask = wdat[13:8];
				end
				reset_power_pkg::IDX_CPU_MISC: begin
					nxt_state.cpu.repeat_cnt = wdat[15:0];
					nxt_state.cpu.mem_alloc = wdat[23:16];
				end
				reset_power_pkg::IDX_CPU_PC: begin
					nxt_state.cpu.pc = wdat[15:0];
				end
				default: ;
			endcase
		end

		// Address phase capture, zero wait states
		nxt_state.ahb_act = addr_ok & mapped;
		nxt_state.ahb_wr = ahb_i.hwrite;
		nxt_state.ahb_idx = idx;
		nxt_state.resp.hreadyout = 1'b1;
		nxt_state.resp.hresp = 1'b0;
		illegal_evt = (addr_ok & ~mapped) | illegal_access_i;

		// Watchdog counts only while its clock runs; active from power-on
		if (state_ff.clk.wdog & watchdog_tick_i & ~nxt_state.wd_dis) begin
			if (state_ff.wd_cnt == 8'hFF) begin
				wd_evt = 1'b1;
			end else begin
				nxt_state.wd_cnt = 8'(state_ff.wd_cnt + 8'h01);
			end
		end

		// Our own drive reads back low, so it must not count as external
		pin_ext = ~reset_pin_n_i & ~state_ff.pin_oe;
		supply_bad = power_on_reset_input_i | low_voltage_i;
		src = 5'h00;
		src[reset_power_pkg::CAUSE_POR] = supply_bad;
		src[reset_power_pkg::CAUSE_PIN] = pin_ext;
		src[reset_power_pkg::CAUSE_WDOG] = wd_evt;
		src[reset_power_pkg::CAUSE_SW] = sw_evt;
		src[reset_power_pkg::CAUSE_ILLEGAL] = illegal_evt;

		// Cause set after the software clear, so a new cause is never lost
		nxt_state.cause = nxt_state.cause | src;

		if (|src) begin
			// Level sources reload the count, holding reset while they last
			nxt_state.drive_cnt = 4'(reset_power_pkg::PIN_DRIVE_CYCLES);
			nxt_state.cpu = reset_power_pkg::CPU_RESET;
			nxt_state.scr_clr = 1'b1;
			nxt_state.scr_set = 1'b0;
			nxt_state.lpm = reset_power_pkg::LPM_LIGHT;
			nxt_state.wd_cnt = 8'h00;
			nxt_state.wd_armed = 1'b0;
			nxt_state.wd_dis = 1'b0;
			// Reset ends any power-down, but clocks must restart first
			case (state_ff.pwr)
				reset_power_pkg::PWR_OSC_DOWN: begin
					nxt_state.pwr = reset_power_pkg::PWR_OSC_WAIT;
					nxt_state.wait_cnt = OSC_LOAD;
				end
				reset_power_pkg::PWR_PLL_DOWN: begin
					nxt_state.pwr = reset_power_pkg::PWR_PLL_WAIT;
					nxt_state.wait_cnt = PLL_LOAD;
				end
				reset_power_pkg::PWR_LIGHT, reset_power_pkg::PWR_DEEP: begin
					nxt_state.pwr = reset_power_pkg::PWR_RUN;
				end
				default: begin
					nxt_state.pwr = state_ff.pwr;
				end
			endcase
		end else begin
			if (state_ff.drive_cnt != 4'h0) begin
				nxt_state.drive_cnt = 4'(state_ff.drive_cnt - 4'h1);
			end
			// Wake by interrupt leaves all held state as it was
			case (state_ff.pwr)
				reset_power_pkg::PWR_RUN: begin
					if (sleep_i & ~state_ff.cpu_reset) begin
						case (state_ff.lpm)
							reset_power_pkg::LPM_LIGHT:    nxt_state.pwr = reset_power_pkg::PWR_LIGHT;
							reset_power_pkg::LPM_DEEP:     nxt_state.pwr = reset_power_pkg::PWR_DEEP;
							reset_power_pkg::LPM_PLL_DOWN: nxt_state.pwr = reset_power_pkg::PWR_PLL_DOWN;
							reset_power_pkg::LPM_OSC_DOWN: nxt_state.pwr = reset_power_pkg::PWR_OSC_DOWN;
							default:                       nxt_state.pwr = reset_power_pkg::PWR_RUN;
						endcase
					end
				end
				reset_power_pkg::PWR_LIGHT: begin
					if (irq_req_i | wake_irq_i | pin_irq_i) begin
						nxt_state.pwr = reset_power_pkg::PWR_RUN;
					end
				end
				reset_power_pkg::PWR_DEEP: begin
					if (wake_irq_i | pin_irq_i) begin
						nxt_state.pwr = reset_power_pkg::PWR_RUN;
					end
				end
				reset_power_pkg::PWR_PLL_DOWN: begin
					if (wake_irq_i | pin_irq_i) begin
						nxt_state.pwr = reset_power_pkg::PWR_PLL_WAIT;
						nxt_state.wait_cnt = PLL_LOAD;
					end
				end
				reset_power_pkg::PWR_OSC_DOWN: begin
					// No on-chip clock runs, only a pin can wake it
					if (pin_irq_i) begin
						nxt_state.pwr = reset_power_pkg::PWR_OSC_WAIT;
						nxt_state.wait_cnt = OSC_LOAD;
					end
				end
				reset_power_pkg::PWR_OSC_WAIT: begin
					if (state_ff.wait_cnt == 16'h0000) begin
						nxt_state.pwr = reset_power_pkg::PWR_PLL_WAIT;
						nxt_state.wait_cnt = PLL_LOAD;
					end else begin
						nxt_state.wait_cnt = 16'(state_ff.wait_cnt - 16'h0001);
					end
				end
				reset_power_pkg::PWR_PLL_WAIT: begin
					if (state_ff.wait_cnt == 16'h0000) begin
						nxt_state.pwr = reset_power_pkg::PWR_RUN;
					end else begin
						nxt_state.wait_cnt = 16'(state_ff.wait_cnt - 16'h0001);
					end
				end
				default: begin
					nxt_state.pwr = reset_power_pkg::PWR_RUN;
				end
			endcase
		end

		// Reset also holds while the wire reads low
		nxt_state.pin_oe = (nxt_state.drive_cnt != 4'h0);
		nxt_state.cpu_reset = (|src) | nxt_state.pin_oe | ~reset_pin_n_i;

		// Gates registered alongside the power state
		nxt_state.clk = clk_map(nxt_state.pwr);

		// A pending reset blocks every maskable grant
		nxt_state.irq_grant = irq_req_i & ~(|src) & ~nxt_state.cpu_reset
			& ~state_ff.cpu.st.irq_disable;

		// Read data from the image after this cycle's write
		nxt_state.resp.hrdata = (addr_ok & mapped & ~ahb_i.hwrite) ? rd_word(idx, nxt_state) : 32'h00000000;
	end

	// State register; accumulator and pointers live in the CPU
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_ff <= reset_power_pkg::STATE_RESET;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Outputs straight from the state register; reset_pin_o is tied low
	assign ahb_o          = state_ff.resp;
	assign reset_pin_o    = 1'b0;
	assign reset_pin_oe_o = state_ff.pin_oe;
	assign cpu_reset_o    = state_ff.cpu_reset;
	assign irq_grant_o    = state_ff.irq_grant;
	assign cpu_init_o     = state_ff.cpu;
	assign clk_gate_o     = state_ff.clk;
	assign pwr_state_o    = state_ff.pwr;

endmodule // reset_and_powerdown_control

/* File: reset_and_powerdown_control_monitor.sv */
// Concurrent checks on the ports of the reset and power-down controller
`timescale 1ns/1ps
module reset_and_powerdown_control_monitor #(
	parameter int OSC_START_CYCLES = 20,
	parameter int PLL_LOCK_CYCLES  = 10
) (
	// Clock and reset
	input wire logic                           ref_clk_i,
	input wire logic                           rst_i,
	// Causes at the inputs
	input wire logic                           reset_pin_n_i,
	input wire logic                           power_on_reset_input_i,
	input wire logic                           low_voltage_i,
	input wire logic                           illegal_access_i,
	input wire logic                           sleep_i,
	input wire logic                           irq_req_i,
	input wire logic                           pin_irq_i,
	// Outputs under watch
	input wire logic                           reset_pin_oe_o,
	input wire logic                           cpu_reset_o,
	input wire logic                           irq_grant_o,
	input wire reset_power_pkg::cpu_init_type  cpu_init_o,
	input wire reset_power_pkg::clk_gate_type  clk_gate_o,
	input wire reset_power_pkg::pwr_state_type pwr_state_o
);
	localparam logic [41:0] GATES = {6'h0E, 6'h02, 6'h00, 6'h0A, 6'h0E, 6'h1E, 6'h3F};
	logic [5:0]                     gate_exp;
	logic                           src;
	logic [15:0]                    dwell;
	reset_power_pkg::pwr_state_type st_q;
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);
	// Gates per state, RUN lowest; outside reset causes
	assign gate_exp = GATES[6 * int'(pwr_state_o) +: 6];
	assign src = !reset_pin_n_i || power_on_reset_input_i || low_voltage_i || illegal_access_i;
	// Cycles spent in the current state
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			st_q  <= reset_power_pkg::PWR_RUN;
			dwell <= 16'h0001;
		end else begin
			st_q  <= pwr_state_o;
			dwell <= (pwr_state_o == st_q) ? dwell + 16'h0001 : 16'h0001;
		end
	end
	a_pin_drive_min: assert property ($rose(reset_pin_oe_o) |-> reset_pin_oe_o [*8])
		else $error("reset pin released early");
	a_supply_hold: assert property (power_on_reset_input_i || low_voltage_i |=> cpu_reset_o && reset_pin_oe_o)
		else $error("supply fault not held in reset");
	a_pin_hold: assert property (!reset_pin_n_i |=> cpu_reset_o)
		else $error("external pin low not held in reset");
	a_illegal_rst: assert property (illegal_access_i |=> reset_pin_oe_o && cpu_reset_o)
		else $error("illegal access gave no reset");
	a_reset_first: assert property (cpu_reset_o && $past(cpu_reset_o) |-> !irq_grant_o)
		else $error("interrupt granted during reset");
	a_init_vals: assert property ($fell(cpu_reset_o) |-> cpu_init_o == reset_power_pkg::CPU_RESET)
		else $error("wrong init values at reset release");
	a_sleep_only: assert property (
		$past(pwr_state_o) == reset_power_pkg::PWR_RUN && pwr_state_o != reset_power_pkg::PWR_RUN |-> $past(sleep_i))
		else $error("power-down entered without sleep");
	a_gate_table: assert property (clk_gate_o == gate_exp)
		else $error("clock gates do not match power state");
	a_light_exit: assert property (pwr_state_o == reset_power_pkg::PWR_LIGHT && irq_req_i |=>
		pwr_state_o == reset_power_pkg::PWR_RUN) else $error("light sleep ignored interrupt");
	a_osc_hold: assert property (pwr_state_o == reset_power_pkg::PWR_OSC_DOWN && !pin_irq_i && !src |=>
		pwr_state_o == reset_power_pkg::PWR_OSC_DOWN) else $error("oscillator down left early");
	a_osc_start: assert property (pwr_state_o == reset_power_pkg::PWR_PLL_WAIT &&
		st_q == reset_power_pkg::PWR_OSC_WAIT |-> dwell inside {[OSC_START_CYCLES - 1:OSC_START_CYCLES + 2]})
		else $error("oscillator start wait wrong length");
	a_pll_relock: assert property (pwr_state_o == reset_power_pkg::PWR_RUN &&
		st_q == reset_power_pkg::PWR_PLL_WAIT |-> dwell inside {[PLL_LOCK_CYCLES - 1:PLL_LOCK_CYCLES + 2]})
		else $error("relock wait wrong length");
endmodule // reset_and_powerdown_control_monitor

/* File: reset_line_model.sv */
// Shared reset wire: pull-up, push-button and the device's open drain
`timescale 1ns/1ps
module reset_line_model (
	// Clock
	input  wire logic ref_clk_i,
	// Parties on the wire
	input  wire logic press_i,
	input  wire logic dut_oe_i,
	output logic      level_o
);
	logic press_ff = 1'b0;
	// Button pulls low for whole clock cycles, never a glitch
	always_ff @(posedge ref_clk_i) press_ff <= press_i;
	// Wire is low while anyone pulls, else the pull-up wins
	assign level_o = !(press_ff || dut_oe_i);
endmodule // reset_line_model

/* File: reset_and_powerdown_control_tb_top.sv */
// Self-checking bench for the reset and power-down controller
`timescale 1ns/1ps
module reset_and_powerdown_control_tb_top;
	logic                           ref_clk_i = 1'b0;
	logic                           rst_i = 1'b1;
	reset_power_pkg::ahb_req_type   m = '0;
	reset_power_pkg::ahb_req_type   req;
	reset_power_pkg::ahb_resp_type  rsp;
	logic                           press = 1'b0, por = 1'b0, lv = 1'b0, ill = 1'b0, tick = 1'b0;
	logic                           sleep = 1'b0, irq = 1'b0, wake = 1'b0, pin_irq = 1'b0;
	logic                           level, oe, cpu_rst, grant;
	reset_power_pkg::clk_gate_type  gate;
	reset_power_pkg::pwr_state_type pwr;
	int                             miscompares = 0;
	int                             tests_run = 0;
	// Clock; slave hreadyout is the bus hready
	initial forever #(reset_power_pkg::CLK_PERIOD_NS / 2) ref_clk_i = ~ref_clk_i;
	always_comb begin
		req = m;
		req.hready = rsp.hreadyout;
	end
	// Short start and relock counts keep the run brief
	reset_and_powerdown_control #(.OSC_START_CYCLES(20), .PLL_LOCK_CYCLES(10)) u_reset_and_powerdown_control (
		.ref_clk_i, .rst_i, .ahb_i(req), .ahb_o(rsp), .reset_pin_n_i(level),
		.power_on_reset_input_i(por), .low_voltage_i(lv), .illegal_access_i(ill), .watchdog_tick_i(tick),
		.reset_pin_o(), .reset_pin_oe_o(oe), .sleep_i(sleep), .irq_req_i(irq), .wake_irq_i(wake),
		.pin_irq_i(pin_irq), .cpu_reset_o(cpu_rst), .irq_grant_o(grant), .cpu_init_o(),
		.clk_gate_o(gate), .pwr_state_o(pwr));
	reset_line_model u_reset_line_model (.ref_clk_i(ref_clk_i), .press_i(press), .dut_oe_i(oe), .level_o(level));
	// Verdict and end of run
	task automatic end_of_test();
		if (miscompares == 0 && tests_run > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// One word; each phase held until hready is high
	task automatic bus(input logic wr_en, input logic [31:0] addr, input logic [31:0] wdata, output logic [31:0] rdata);
		@(posedge ref_clk_i);
		m.hsel <= 1'b1;
		m.haddr <= addr;
		m.htrans <= 2'h2;
		m.hwrite <= wr_en;
		m.hsize <= 3'h2;
		do @(posedge ref_clk_i); while (rsp.hreadyout !== 1'b1);
		m.hsel <= 1'b0;
		m.htrans <= 2'h0;
		m.hwdata <= wdata;
		do @(posedge ref_clk_i); while (rsp.hreadyout !== 1'b1);
		rdata = rsp.hrdata;
	endtask
	task automatic wr(input logic [5:0] idx, input logic [31:0] v);
		logic [31:0] d;
		bus(1'b1, {24'h0, idx, 2'h0}, v, d);
	endtask
	task automatic rd_chk(input string what, input logic [5:0] idx, input logic [31:0] exp);
		logic [31:0] d;
		bus(1'b0, {24'h0, idx, 2'h0}, 32'h0, d);
		chk(what, d, exp);
	endtask
	// Sticky cause bits: read, then clear
	task automatic cause_is(input logic [31:0] exp);
		rd_chk("cause", reset_power_pkg::IDX_CAUSE, exp);
		wr(reset_power_pkg::IDX_CAUSE, 32'h1F);
	endtask
	// Bounded wait for a device reset to start and end
	task automatic settle();
		int n;
		for (n = 0; cpu_rst !== 1'b1 && n < 20; n++) @(posedge ref_clk_i);
		for (n = 0; cpu_rst !== 1'b0 && n < 300; n++) @(posedge ref_clk_i);
		chk("reset length", {31'h0, n > 6}, 32'h1);
	endtask
	task automatic init_chk();
		rd_chk("status", reset_power_pkg::IDX_CPU_STATUS, 32'h7C6);
		rd_chk("irq regs", reset_power_pkg::IDX_CPU_IRQ, 32'h0);
		rd_chk("misc", reset_power_pkg::IDX_CPU_MISC, 32'h0);
		rd_chk("pc", reset_power_pkg::IDX_CPU_PC, 32'h0);
	endtask
	task automatic ticks(input int n);
		repeat (n) begin
			tick <= 1'b1;
			@(posedge ref_clk_i);
			tick <= 1'b0;
			@(posedge ref_clk_i);
		end
	endtask
	task automatic wait_pwr(input reset_power_pkg::pwr_state_type s, input int lim);
		int n;
		for (n = 0; pwr !== s && n < lim; n++) @(posedge ref_clk_i);
		chk("pwr state", {29'h0, pwr}, {29'h0, s});
	endtask
	// Both software reset bits, CPU state dirtied first
	task automatic t_sw_reset();
		for (int k = 0; k < 2; k++) begin
			wr(reset_power_pkg::IDX_CPU_STATUS, 32'h0);
			wr(reset_power_pkg::IDX_CPU_IRQ, 32'h3F3F);
			wr(reset_power_pkg::IDX_CPU_MISC, 32'hAB1234);
			wr(reset_power_pkg::IDX_SYS_CTRL, k ? 32'h0 : 32'hC000);
			settle();
			cause_is(32'h8);
			init_chk();
		end
	endtask
	// Key and control codes, counter overflow
	task automatic t_wdog();
		ticks(10);
		wr(reset_power_pkg::IDX_WD_KEY, 32'h55);
		wr(reset_power_pkg::IDX_WD_KEY, 32'hAA);
		wr(reset_power_pkg::IDX_WD_CTRL, 32'h28);
		rd_chk("wd count", reset_power_pkg::IDX_WD_COUNT, 32'h0);
		ticks(255);
		rd_chk("wd count", reset_power_pkg::IDX_WD_COUNT, 32'hFF);
		cause_is(32'h0);
		ticks(1);
		settle();
		cause_is(32'h4);
		wr(reset_power_pkg::IDX_WD_KEY, 32'h12);
		settle();
		cause_is(32'h4);
		wr(reset_power_pkg::IDX_WD_CTRL, 32'h0);
		settle();
		cause_is(32'h4);
	endtask
	// Unmapped bus places and the outside illegal strobe
	task automatic t_illegal();
		logic [31:0] d;
		bus(1'b1, 32'h100, 32'h0, d);
		settle();
		cause_is(32'h10);
		rd_chk("unmapped", 6'h0B, 32'h0);
		settle();
		cause_is(32'h10);
		ill <= 1'b1;
		@(posedge ref_clk_i);
		ill <= 1'b0;
		settle();
		cause_is(32'h10);
	endtask
	// Held pin, supply faults and a one-cycle press
	task automatic t_pin_supply();
		for (int k = 0; k < 4; k++) begin
			press <= (k == 0 || k == 3);
			por <= (k == 1);
			lv <= (k == 2);
			repeat (k == 3 ? 1 : 20) @(posedge ref_clk_i);
			if (k < 3) chk("held", {31'h0, cpu_rst}, 32'h1);
			press <= 1'b0;
			por <= 1'b0;
			lv <= 1'b0;
			settle();
			cause_is((k == 1 || k == 2) ? 32'h1 : 32'h2);
		end
	endtask
	// Reset outranks a granted interrupt
	task automatic t_grant();
		wr(reset_power_pkg::IDX_CPU_STATUS, 32'h0);
		irq <= 1'b1;
		repeat (3) @(posedge ref_clk_i);
		chk("grant", {31'h0, grant}, 32'h1);
		ill <= 1'b1;
		@(posedge ref_clk_i);
		ill <= 1'b0;
		repeat (3) @(posedge ref_clk_i);
		chk("grant in reset", {31'h0, grant}, 32'h0);
		irq <= 1'b0;
		settle();
		cause_is(32'h10);
	endtask
	// Each mode: entry, gates, stays asleep (wrong wake driven in oscillator down only), right wake, state kept
	task automatic t_sleep();
		logic [23:0] gates;
		gates = {6'h1E, 6'h0E, 6'h0A, 6'h00};
		for (int k = 0; k < 4; k++) begin
			wr(reset_power_pkg::IDX_CLK_CTRL0, 32'(k));
			wr(reset_power_pkg::IDX_CPU_MISC, 32'h5A5A);
			sleep <= 1'b1;
			@(posedge ref_clk_i);
			sleep <= 1'b0;
			wait_pwr(reset_power_pkg::pwr_state_type'(k + 1), 10);
			chk("gates", {26'h0, gate}, {26'h0, gates[18 - 6 * k +: 6]});
			wake <= (k == 3);
			repeat (5) @(posedge ref_clk_i);
			chk("stay asleep", {29'h0, pwr}, 32'(k + 1));
			irq <= (k == 0);
			wake <= (k == 1 || k == 2);
			pin_irq <= (k == 3);
			wait_pwr(reset_power_pkg::PWR_RUN, 100);
			chk("grant masked", {31'h0, grant}, 32'h0);
			irq <= 1'b0;
			wake <= 1'b0;
			pin_irq <= 1'b0;
			rd_chk("kept", reset_power_pkg::IDX_CPU_MISC, 32'h5A5A);
		end
	endtask
	// Main sequence
	initial begin
		repeat (6) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		settle();
		cause_is(32'h1);
		init_chk();
		t_sw_reset();
		t_wdog();
		t_illegal();
		t_pin_supply();
		t_grant();
		t_sleep();
		end_of_test();
	end
	// Hang guard, several times the expected run
	initial begin
		repeat (20000) @(posedge ref_clk_i);
		miscompares++;
		end_of_test();
	end
endmodule // reset_and_powerdown_control_tb_top
bind reset_and_powerdown_control reset_and_powerdown_control_monitor #(
	.OSC_START_CYCLES(OSC_START_CYCLES), .PLL_LOCK_CYCLES(PLL_LOCK_CYCLES)
) u_reset_and_powerdown_control_monitor (
	.ref_clk_i, .rst_i, .reset_pin_n_i, .power_on_reset_input_i, .low_voltage_i, .illegal_access_i,
	.sleep_i, .irq_req_i, .pin_irq_i, .reset_pin_oe_o, .cpu_reset_o, .irq_grant_o, .cpu_init_o,
	.clk_gate_o, .pwr_state_o);
